// >>> logic/uti_top.sv
// uart timing slice: apb registers, rx idle timeout, tx framing with gap,
// baud generator, line polarity and infrared direction
// assumes the rx fifo push/empty and tx byte stream are on i_clk
`timescale 1ns/1ps
`default_nettype none
module uti_top
	import uti_pkg::*;
(
	input  wire logic                     i_clk,          // 200 MHz clock
	input  wire logic                     i_rst,          // async reset, high
	input  wire logic                     i_psel,         // apb select
	input  wire logic                     i_penable,      // apb enable
	input  wire logic                     i_pwrite,       // apb write
	input  wire logic [uti_pkg::UTI_AW-1:0] i_paddr,      // apb byte address
	input  wire logic [31:0]              i_pwdata,       // apb write data
	input  wire logic [3:0]               i_pstrb,        // apb byte strobes
	output logic      [31:0]              o_prdata,       // apb read data
	output logic                          o_pready,       // apb ready
	output logic                          o_pslverr,      // apb error
	input  wire logic                     i_rx_fifo_push, // word into rx fifo
	input  wire logic                     i_rx_fifo_empty,// rx fifo empty
	input  wire logic                     i_rx,           // rx pin
	output logic                          o_rx_line,      // rx to decoder
	output logic                          o_rx_sample_tick,// oversample pulse
	input  wire logic                     i_tx_valid,     // tx byte offered
	input  wire logic [7:0]               i_tx_data,      // tx byte
	output logic                          o_tx_ready,     // tx byte taken
	output logic                          o_tx,           // tx pin
	output logic                          o_ir_tx_en,     // ir transmitter on
	output logic                          o_ir_rx_en,     // ir receiver on
	output logic                          o_irq           // level interrupt
);
	typedef struct packed {
		logic [31:0]      idle_gap;
		logic [31:0]      baud;
		logic [31:0]      ir;
		logic [EV_N-1:0]  status;
		logic [EV_N-1:0]  enable;
		logic             irq;
		logic             pready;
		logic             pslverr;
		logic [31:0]      prdata;
		logic             rx_line;
		logic             rx_tick;
		logic [7:0]       idle_cnt;
		logic             idle_run;
		uti_tx_st_t       tx_st;
		logic             tx_have;
		logic             tx_ready;
		logic [7:0]       tx_buf;
		logic [7:0]       tx_shift;
		logic [2:0]       bit_cnt;
		logic [7:0]       gap_cnt;
		logic             tx_level;
		logic             tx_out;
		logic             ir_tx_en;
		logic             ir_rx_en;
	} uti_top_t;

	localparam uti_top_t RST_S = '{
		idle_gap: RST_IDLE_GAP,
		baud:     RST_BAUD,
		ir:       RST_IR,
		status:   '0,
		enable:   '0,
		irq:      1'b0,
		pready:   1'b0,
		pslverr:  1'b0,
		prdata:   32'h0000_0000,
		rx_line:  1'b1,
		rx_tick:  1'b0,
		idle_cnt: 8'h00,
		idle_run: 1'b0,
		tx_st:    TX_IDLE,
		tx_have:  1'b0,
		tx_ready: 1'b1,
		tx_buf:   8'h00,
		tx_shift: 8'h00,
		bit_cnt:  3'h0,
		gap_cnt:  8'h00,
		tx_level: 1'b1,
		tx_out:   1'b1,
		ir_tx_en: 1'b0,
		ir_rx_en: 1'b1
	};

	uti_top_t s_q;
	uti_top_t s_d;
	uti_baud_if bif ();
	logic rx_sync;

	uti_sync #(
		.W (1)
	) u_rx_sync (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_d   (i_rx),
		.o_q   (rx_sync)
	);

	uti_baud_gen u_baud (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.bif   (bif)
	);

	assign bif.presc_en  = s_q.baud[PEN_BIT];
	assign bif.presc_one = s_q.baud[PONE_BIT];
	assign bif.presc_val = s_q.baud[PX_LSB +: PX_W];
	assign bif.divisor   = s_q.baud[BRD_LSB +: BRD_W];

	// strobe-merged write of one register, reserved bits forced to zero
	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  strb,
		input logic [31:0] mask
	);
		logic [31:0] be;
		be = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = ((old_v & ~be) | (new_v & be)) & mask;
	endfunction : merge

	logic            acc_wait;
	logic            acc_done;
	logic [EV_N-1:0] ev_set;
	logic [EV_N-1:0] hw_clr;
	logic [EV_N-1:0] sw_clr;
	logic [7:0]      gap_val;
	logic [7:0]      cmp_val;
	logic            tick;
	logic            next_char;
	logic [31:0]     rd_v;
	logic            rd_err;

	always_comb begin
		s_d       = s_q;
		ev_set    = '0;
		hw_clr    = '0;
		sw_clr    = '0;
		next_char = 1'b0;
		rd_v      = 32'h0000_0000;
		rd_err    = 1'b0;
		tick      = bif.bit_tick;
		gap_val   = s_q.idle_gap[GAP_LSB +: 8];
		cmp_val   = s_q.idle_gap[CMP_LSB +: 8];
		// one wait state: ready rises the cycle after the access phase opens
		acc_wait  = i_psel && i_penable && !s_q.pready;
		acc_done  = i_psel && i_penable && s_q.pready;

		case (i_paddr)
			OFF_IDLE_GAP: rd_v = s_q.idle_gap;
			OFF_BAUD:     rd_v = s_q.baud;
			OFF_IR:       rd_v = s_q.ir;
			OFF_STATUS:   rd_v = {{(32-EV_N){1'b0}}, s_q.status};
			OFF_CLEAR:    rd_v = 32'h0000_0000;
			OFF_ENABLE:   rd_v = {{(32-EV_N){1'b0}}, s_q.enable};
			default:      rd_err = 1'b1;
		endcase
		s_d.pready = acc_wait;
		if (acc_wait) begin
			s_d.prdata  = i_pwrite ? 32'h0000_0000 : rd_v;
			s_d.pslverr = rd_err;
		end else begin
			s_d.prdata  = 32'h0000_0000;
			s_d.pslverr = 1'b0;
		end
		if (acc_done && i_pwrite) begin
			case (i_paddr)
				OFF_IDLE_GAP: begin
					s_d.idle_gap = merge(s_q.idle_gap, i_pwdata, i_pstrb,
						MASK_IDLE_GAP);
				end
				OFF_BAUD: begin
					s_d.baud = merge(s_q.baud, i_pwdata, i_pstrb, MASK_BAUD);
				end
				OFF_IR: begin
					s_d.ir = merge(s_q.ir, i_pwdata, i_pstrb, MASK_IR);
				end
				OFF_CLEAR: begin
					if (i_pstrb[0]) begin
						sw_clr = i_pwdata[EV_N-1:0];
					end
				end
				OFF_ENABLE: begin
					if (i_pstrb[0]) begin
						s_d.enable = i_pwdata[EV_N-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		s_d.rx_line = rx_sync ^ s_q.ir[RX_POLARITY_INVERT_BIT];
		s_d.rx_tick = bif.sample_tick;
		s_d.ir_tx_en = s_d.ir[IR_TX_BIT];
		s_d.ir_rx_en = !s_d.ir[IR_TX_BIT];

		if (i_rx_fifo_push) begin
			s_d.idle_cnt = 8'h00;
			s_d.idle_run = 1'b1;
		end else if (i_rx_fifo_empty) begin
			s_d.idle_run = 1'b0;
		end else if (s_q.idle_run && s_q.idle_cnt == cmp_val) begin
			ev_set[EV_IDLE] = 1'b1;
			s_d.idle_run    = 1'b0;
		end else if (s_q.idle_run && tick) begin
			s_d.idle_cnt = s_q.idle_cnt + 8'h01;
		end
		hw_clr[EV_IDLE] = i_rx_fifo_push || i_rx_fifo_empty;

		// tx byte handshake; one byte held while another is on the line
		if (i_tx_valid && s_q.tx_ready) begin
			s_d.tx_have = 1'b1;
			s_d.tx_buf  = i_tx_data;
		end
		// frame steps move only on bit ticks so every bit is a full period
		case (s_q.tx_st)
			TX_IDLE: begin
				if (tick && s_q.tx_have) begin
					next_char = 1'b1;
				end
			end
			TX_START: begin
				if (tick) begin
					s_d.tx_st    = TX_DATA;
					s_d.tx_level = s_q.tx_shift[0];
					s_d.bit_cnt  = 3'h0;
				end
			end
			TX_DATA: begin
				if (tick) begin
					if (s_q.bit_cnt == 3'(DATA_BITS - 1)) begin
						s_d.tx_st    = TX_STOP;
						s_d.tx_level = 1'b1;
					end else begin
						s_d.tx_shift = {1'b0, s_q.tx_shift[7:1]};
						s_d.tx_level = s_q.tx_shift[1];
						s_d.bit_cnt  = s_q.bit_cnt + 3'h1;
					end
				end
			end
			TX_STOP: begin
				if (tick) begin
					ev_set[EV_TXDONE] = 1'b1;
					if (gap_val == 8'h00) begin
						next_char = 1'b1;
					end else begin
						s_d.tx_st   = TX_GAP;
						s_d.gap_cnt = 8'h00;
					end
				end
			end
			TX_GAP: begin
				if (tick) begin
					if ({1'b0, s_q.gap_cnt} + 9'h001 >= {1'b0, gap_val}) begin
						next_char = 1'b1;
					end else begin
						s_d.gap_cnt = s_q.gap_cnt + 8'h01;
					end
				end
			end
			default: begin
				s_d.tx_st    = TX_IDLE;
				s_d.tx_level = 1'b1;
			end
		endcase
		if (next_char) begin
			if (s_q.tx_have) begin
				s_d.tx_st    = TX_START;
				s_d.tx_level = 1'b0;
				s_d.tx_shift = s_q.tx_buf;
				s_d.tx_have  = 1'b0;
			end else begin
				s_d.tx_st    = TX_IDLE;
				s_d.tx_level = 1'b1;
			end
		end
		s_d.tx_ready = !s_d.tx_have;
		s_d.tx_out = s_d.tx_level ^ s_d.ir[TX_POLARITY_INVERT_BIT];

		// sticky status: a set in the clearing cycle survives
		s_d.status = (s_q.status & ~hw_clr & ~sw_clr) | ev_set;
		s_d.irq    = |(s_d.status & s_d.enable);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= RST_S;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_prdata         = s_q.prdata;
	assign o_pready         = s_q.pready;
	assign o_pslverr        = s_q.pslverr;
	assign o_rx_line        = s_q.rx_line;
	assign o_rx_sample_tick = s_q.rx_tick;
	assign o_tx_ready       = s_q.tx_ready;
	assign o_tx             = s_q.tx_out;
	assign o_ir_tx_en       = s_q.ir_tx_en;
	assign o_ir_rx_en       = s_q.ir_rx_en;
	assign o_irq            = s_q.irq;
endmodule : uti_top
`default_nettype wire

// >>> pkg/uti_pkg.sv
// constants, field layout and types of the uart timing and infrared slice
// assumes a 32-bit apb slave at 200 MHz with one aligned word per register
package uti_pkg;
	localparam int unsigned UTI_AW = 12;
	localparam logic [11:0] OFF_IDLE_GAP = 12'h020;
	localparam logic [11:0] OFF_BAUD     = 12'h024;
	localparam logic [11:0] OFF_IR       = 12'h028;
	localparam logic [11:0] OFF_STATUS   = 12'h040;
	localparam logic [11:0] OFF_CLEAR    = 12'h044;
	localparam logic [11:0] OFF_ENABLE   = 12'h048;
	localparam logic [31:0] RST_IDLE_GAP = 32'h0000_0000;
	localparam logic [31:0] RST_BAUD     = 32'h0f00_0000;
	localparam logic [31:0] RST_IR       = 32'h0000_0040;
	localparam logic [31:0] MASK_IDLE_GAP = 32'h0000_ffff;
	localparam logic [31:0] MASK_BAUD     = 32'h3f00_ffff;
	localparam logic [31:0] MASK_IR       = 32'h0000_0062;
	localparam int unsigned GAP_LSB  = 8;
	localparam int unsigned CMP_LSB  = 0;
	localparam int unsigned BRD_LSB  = 0;
	localparam int unsigned BRD_W    = 16;
	localparam int unsigned PX_LSB   = 24;
	localparam int unsigned PX_W     = 4;
	localparam int unsigned PONE_BIT = 28;
	localparam int unsigned PEN_BIT  = 29;
	localparam int unsigned RX_POLARITY_INVERT_BIT = 6;
	localparam int unsigned TX_POLARITY_INVERT_BIT = 5;
	localparam int unsigned IR_TX_BIT  = 1;
	localparam int unsigned EV_N      = 2;
	localparam int unsigned EV_IDLE   = 0;
	localparam int unsigned EV_TXDONE = 1;
	localparam logic [3:0] M_FIXED_LIM = 4'hf;
	localparam logic [16:0] DIV_OFFSET = 17'h00002;
	localparam int unsigned DATA_BITS = 8;
	typedef enum logic [4:0] {
		TX_IDLE  = 5'b00001,
		TX_START = 5'b00010,
		TX_DATA  = 5'b00100,
		TX_STOP  = 5'b01000,
		TX_GAP   = 5'b10000
	} uti_tx_st_t;
endpackage : uti_pkg

// >>> pkg/uti_baud_if.sv
// baud configuration and tick pulses between the top and the rate generator
// assumes both ends on the same clock
`timescale 1ns/1ps
`default_nettype none
interface uti_baud_if;
	logic        presc_en;
	logic        presc_one;
	logic [3:0]  presc_val;
	logic [15:0] divisor;
	logic        sample_tick;
	logic        bit_tick;
	modport gen (
		input  presc_en, presc_one, presc_val, divisor,
		output sample_tick, bit_tick
	);
	modport user (
		output presc_en, presc_one, presc_val, divisor,
		input  sample_tick, bit_tick
	);
endinterface : uti_baud_if
`default_nettype wire

// >>> logic/uti_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes the input is asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module uti_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk, // system clock
	input  wire logic         i_rst, // async reset, high
	input  wire logic [W-1:0] i_d,   // asynchronous input
	output logic      [W-1:0] o_q    // synchronised output
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} uti_sync_t;
	uti_sync_t s_q;
	uti_sync_t s_d;
	always_comb begin
		s_d    = s_q;
		s_d.s1 = i_d;
		s_d.s2 = s_q.s1;
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign o_q = s_q.s2;
endmodule : uti_sync
`default_nettype wire

// >>> logic/uti_baud_gen.sv
// baud rate generator: divisor stage then oversampling prescale stage
// assumes configuration may change at any time; counters recover by >=
`timescale 1ns/1ps
`default_nettype none
module uti_baud_gen
	import uti_pkg::*;
(
	input  wire logic i_clk, // system clock
	input  wire logic i_rst, // async reset, high
	uti_baud_if.gen   bif    // config in, ticks out
);
	typedef struct packed {
		logic [16:0] div_cnt;
		logic [3:0]  m_cnt;
		logic        sample_tick;
		logic        bit_tick;
	} uti_baud_t;
	uti_baud_t s_q;
	uti_baud_t s_d;
	logic [3:0]  m_lim;
	logic [16:0] div_lim;
	always_comb begin
		m_lim = M_FIXED_LIM;
		if (bif.presc_en && bif.presc_one) begin
			m_lim = 4'h0;
		end else if (bif.presc_en) begin
			m_lim = bif.presc_val;
		end
		div_lim = {1'b0, bif.divisor} + DIV_OFFSET - 17'h00001;
		s_d = s_q;
		s_d.sample_tick = 1'b0;
		s_d.bit_tick = 1'b0;
		if (s_q.div_cnt >= div_lim) begin
			s_d.div_cnt = '0;
			s_d.sample_tick = 1'b1;
			if (s_q.m_cnt >= m_lim) begin
				s_d.m_cnt = '0;
				s_d.bit_tick = 1'b1;
			end else begin
				s_d.m_cnt = s_q.m_cnt + 4'h1;
			end
		end else begin
			s_d.div_cnt = s_q.div_cnt + 17'h00001;
		end
	end
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign bif.sample_tick = s_q.sample_tick;
	assign bif.bit_tick    = s_q.bit_tick;
endmodule : uti_baud_gen
`default_nettype wire

// >>> testbench/uti_top_sva.sv
// port assertions for the uart timing slice
// assumes a bind into uti_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module uti_top_sva (
	input wire logic        i_clk,            // clock
	input wire logic        i_rst,            // reset
	input wire logic        i_psel,           // select
	input wire logic        i_penable,        // enable
	input wire logic        o_pready,         // ready
	input wire logic        o_pslverr,        // error
	input wire logic [31:0] o_prdata,         // read data
	input wire logic        i_rx_fifo_empty,  // fifo empty
	input wire logic        i_tx_valid,       // byte offered
	input wire logic        o_tx_ready,       // byte taken
	input wire logic        o_rx_sample_tick, // tick
	input wire logic        o_ir_tx_en,       // ir tx on
	input wire logic        o_ir_rx_en,       // ir rx on
	input wire logic        o_irq             // interrupt
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_access;
		i_psel && i_penable && !o_pready;
	endsequence
	sequence s_answer;
		o_pready ##1 !o_pready;
	endsequence
	property p_wait; s_access |=> s_answer; endproperty
	property p_setup; i_psel && !i_penable |=> !o_pready; endproperty
	property p_err; o_pslverr |-> o_pready; endproperty
	property p_rdz; !o_pready |-> o_prdata == 32'h0; endproperty
	property p_take; i_tx_valid && o_tx_ready |=> !o_tx_ready; endproperty
	property p_tick; o_rx_sample_tick |=> !o_rx_sample_tick; endproperty
	property p_ir; o_ir_tx_en != o_ir_rx_en; endproperty
	property p_empty; i_rx_fifo_empty [*3] |-> !o_irq; endproperty
	a_wait: assert property (p_wait)
		else $error("ready not one cycle after access");
	a_setup: assert property (p_setup)
		else $error("ready in setup answer");
	a_err: assert property (p_err)
		else $error("error without ready");
	a_rdz: assert property (p_rdz)
		else $error("read data outside ready");
	a_take: assert property (p_take)
		else $error("tx ready held after take");
	a_tick: assert property (p_tick)
		else $error("sample ticks back to back");
	a_ir: assert property (p_ir)
		else $error("ir enables not exclusive");
	a_empty: assert property (p_empty)
		else $error("irq stays with fifo empty");
endmodule : uti_top_sva
`default_nettype wire

// >>> testbench/uti_line_model.sv
// serial partner: decodes frames on the tx pin, drives the rx pin
// assumes 8N1 lsb first, idle high, first data bit of each byte 1
`timescale 1ns/1ps
`default_nettype none
module uti_line_model (
	input  wire logic       i_clk,    // clock
	input  wire logic       i_line,   // tx pin of the block
	output var  logic       o_rx,     // rx pin of the block
	output var  logic [7:0] o_byte,   // last byte decoded
	output int              o_period, // start bit length, clocks
	output int              o_idle,   // high time before last start
	output int              o_frames  // frames decoded
);
	int n;
	initial begin
		o_rx = 1'b1;
		o_byte = 8'h00;
		o_period = 0;
		o_frames = 0;
		forever begin
			n = 0;
			while (i_line !== 1'b0) begin
				@(posedge i_clk);
				n++;
			end
			// counting began mid stop bit
			o_idle = n + o_period / 2;
			o_period = 0;
			while (i_line === 1'b0) begin
				@(posedge i_clk);
				o_period++;
			end
			repeat (o_period / 2) @(posedge i_clk);
			for (int k = 0; k < 8; k++) begin
				o_byte[k] = i_line;
				repeat (o_period) @(posedge i_clk);
			end
			o_frames++;
		end
	end
	task put(input logic v);
		@(posedge i_clk);
		o_rx <= v;
	endtask : put
endmodule : uti_line_model
`default_nettype wire

// >>> testbench/uti_top_test.sv
// self-checking bench for uti_top with a serial line partner
// assumes uti_pkg, the design and the line model compile first
`timescale 1ns/1ps
`default_nettype none
module uti_top_test;
	import uti_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_psel = 1'b0;
	logic        i_penable = 1'b0;
	logic        i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h000;
	logic [31:0] i_pwdata = 32'h0;
	logic [3:0]  i_pstrb = 4'hf;
	logic        i_rx_fifo_push = 1'b0;
	logic        i_rx_fifo_empty = 1'b1;
	logic        i_rx;
	logic        i_tx_valid = 1'b0;
	logic [7:0]  i_tx_data = 8'h00;
	logic [31:0] o_prdata;
	logic        o_pready, o_pslverr, o_rx_line, o_rx_sample_tick;
	logic        o_tx_ready, o_tx, o_ir_tx_en, o_ir_rx_en, o_irq;
	logic [7:0]  byte_seen;
	int          period, idle, frames, n;
	int          n_fail = 0;
	int          compares = 0;
	uti_top dut_u (.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
		.i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_rx_fifo_push,
		.i_rx_fifo_empty, .i_rx, .o_rx_line, .o_rx_sample_tick, .i_tx_valid,
		.i_tx_data, .o_tx_ready, .o_tx, .o_ir_tx_en, .o_ir_rx_en, .o_irq);
	uti_line_model line_u (.i_clk, .i_line(o_tx), .o_rx(i_rx),
		.o_byte(byte_seen), .o_period(period), .o_idle(idle), .o_frames(frames));
	always #2.5 i_clk = ~i_clk;
	task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		@(posedge i_clk);
		// no cycle count assumed; the watchdog ends a hung access
		while (o_pready !== 1'b1) begin
			@(posedge i_clk);
		end
		r = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task chk(input string w, input logic [11:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		cmp(w, x, r);
	endtask : chk
	task send(input logic [7:0] b);
		@(posedge i_clk);
		i_tx_valid <= 1'b1;
		i_tx_data <= b;
		do @(posedge i_clk); while (o_tx_ready !== 1'b1);
		i_tx_valid <= 1'b0;
	endtask : send
	task push;
		@(posedge i_clk);
		i_rx_fifo_push <= 1'b1;
		@(posedge i_clk);
		i_rx_fifo_push <= 1'b0;
	endtask : push
	task wait_irq;
		n = 0;
		while (o_irq !== 1'b1 && n < 1000) begin
			@(posedge i_clk);
			n++;
		end
	endtask : wait_irq
	task t_regs;
		logic [11:0] offs [3];
		logic [31:0] rsts [3];
		logic [31:0] msks [3];
		logic [31:0] r;
		logic e;
		offs = '{OFF_IDLE_GAP, OFF_BAUD, OFF_IR};
		msks = '{MASK_IDLE_GAP, MASK_BAUD, MASK_IR};
		rsts = '{32'h0, 32'h0f00_0000, 32'h0000_0040};
		for (int i = 0; i < 3; i++) begin
			chk("reset value", offs[i], rsts[i]);
			wr(offs[i], 32'hffff_ffff);
			chk("reserved bits", offs[i], msks[i]);
			wr(offs[i], rsts[i]);
		end
		apb(1'b0, 12'h100, 32'h0, r, e);
		cmp("unmapped error", 32'h1, {31'h0, e});
		cmp("unmapped data", 32'h0, r);
		$display("t_regs done");
	endtask : t_regs
	task t_line;
		logic [31:0] v [6];
		v = '{32'h00, 32'h02, 32'h20, 32'h40, 32'h60, 32'h62};
		// prescale stays off while the infrared bits move
		for (int i = 0; i < 6; i++) begin
			wr(OFF_IR, v[i]);
			line_u.put(i[0]);
			repeat (6) @(posedge i_clk);
			cmp("line pins", {28'h0, v[i][1], ~v[i][1], ~v[i][5], i[0] ^ v[i][6]},
				{28'h0, o_ir_tx_en, o_ir_rx_en, o_tx, o_rx_line});
		end
		wr(OFF_IR, 32'h40);
		line_u.put(1'b1);
		// inverted idle looks like frames to the line model; let it drain
		repeat (600) @(posedge i_clk);
		$display("t_line done");
	endtask : t_line
	task t_rate;
		int f;
		int per [3];
		int gap [3];
		logic [31:0] bd [3];
		// prescale kept at 8 and divisor at 3 where they are limited
		bd = '{32'h0000_0000, 32'h2800_0001, 32'h3000_0003};
		per = '{32, 27, 5};
		gap = '{0, 2, 255};
		for (int i = 0; i < 3; i++) begin
			wr(OFF_BAUD, bd[i]);
			wr(OFF_IDLE_GAP, 32'(gap[i]) << 8);
			f = frames;
			send(8'h55);
			send(8'h55);
			send(8'ha3);
			n = 0;
			while (frames < f + 3 && n < 20000) begin
				@(posedge i_clk);
				n++;
			end
			cmp("bit period", per[i], period);
			cmp("stop plus gap", (gap[i] + 1) * per[i], idle);
			cmp("byte", 32'ha3, {24'h0, byte_seen});
			cmp("frames", 32'(f + 3), 32'(frames));
			// sample tick spacing is divisor+2 clocks in every mode
			while (o_rx_sample_tick !== 1'b1) begin
				@(posedge i_clk);
			end
			@(posedge i_clk);
			n = 1;
			while (o_rx_sample_tick !== 1'b1) begin
				@(posedge i_clk);
				n++;
			end
			cmp("sample tick", 32'(bd[i][15:0]) + 32'd2, 32'(n));
		end
		$display("t_rate done");
	endtask : t_rate
	task t_idle;
		// compare of 40 keeps to the advised range
		// last stop bit still on the line sets tx done; let it end first
		repeat (20) @(posedge i_clk);
		wr(OFF_CLEAR, 32'h3);
		wr(OFF_ENABLE, 32'h1);
		wr(OFF_IDLE_GAP, 32'd40);
		@(posedge i_clk);
		i_rx_fifo_empty <= 1'b0;
		push;
		repeat (100) @(posedge i_clk);
		push;
		wait_irq;
		cmp("idle latency", 32'h1, {31'h0, (n >= 195 && n <= 204)});
		chk("status", OFF_STATUS, 32'h1);
		wr(OFF_ENABLE, 32'h0);
		repeat (3) @(posedge i_clk);
		cmp("irq masked", 32'h0, {31'h0, o_irq});
		wr(OFF_CLEAR, 32'h1);
		chk("status cleared", OFF_STATUS, 32'h0);
		wr(OFF_ENABLE, 32'h1);
		push;
		wait_irq;
		push;
		repeat (3) @(posedge i_clk);
		cmp("irq after word", 32'h0, {31'h0, o_irq});
		wait_irq;
		cmp("irq again", 32'h1, {31'h0, o_irq});
		@(posedge i_clk);
		i_rx_fifo_empty <= 1'b1;
		repeat (4) @(posedge i_clk);
		cmp("irq on empty", 32'h0, {31'h0, o_irq});
		$display("t_idle done");
	endtask : t_idle
	task complete_run;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (20) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		cmp("irq reset", 32'h0, {31'h0, o_irq});
		t_regs;
		t_line;
		t_rate;
		t_idle;
		complete_run;
	end
	initial begin
		repeat (40000) @(posedge i_clk);
		n_fail++;
		complete_run;
	end
endmodule : uti_top_test
bind uti_top uti_top_sva chk_u (.i_clk, .i_rst, .i_psel, .i_penable,
	.o_pready, .o_pslverr, .o_prdata, .i_rx_fifo_empty, .i_tx_valid,
	.o_tx_ready, .o_rx_sample_tick, .o_ir_tx_en, .o_ir_rx_en, .o_irq);
`default_nettype wire
